/* rtl/rqds_pkg.sv */
// Package: register map, field layout and reset values of the requantizer/sync bank
package rqds_pkg;
   localparam int RQDS_CHANNELS = 4;
   localparam logic [7:0] RQDS_ADDR_SYNC = 8'h3A;
   localparam logic [7:0] RQDS_ADDR_CTRL = 8'h3C;
   localparam logic [7:0] RQDS_ADDR_TUNE = 8'h3E;
   localparam logic [7:0] RQDS_RST_SYNC = 8'h00;
   localparam logic [7:0] RQDS_RST_CTRL = 8'h00;
   localparam logic [7:0] RQDS_RST_TUNE = 8'h1C;
   // Field positions
   localparam int RQDS_SYNC_MASTER = 0;
   localparam int RQDS_SYNC_DIVEN = 1;
   localparam int RQDS_SYNC_MODE = 2;
   localparam int RQDS_CTRL_EN = 0;
   localparam int RQDS_CTRL_FRAC_LO = 1;
   localparam int RQDS_CTRL_PINDIS = 4;
   // Writable-bit masks; the rest reads zero
   localparam logic [7:0] RQDS_MASK_SYNC = 8'h07;
   localparam logic [7:0] RQDS_MASK_CTRL = 8'h1F;
   localparam logic [7:0] RQDS_MASK_TUNE = 8'h3F;
   // Bandwidth fraction codes
   typedef enum logic [2:0]
   {
      RQDS_FRAC22 = 3'b000,
      RQDS_FRAC33 = 3'b001,
      RQDS_FRAC36 = 3'b010
   } rqds_frac_t;
   // Count of valid tuning words per mode
   localparam logic [6:0] RQDS_TUNES_22 = 7'h39;
   localparam logic [6:0] RQDS_TUNES_33 = 7'h22;
   localparam logic [6:0] RQDS_TUNES_36 = 7'h1C;
   // Band shift per tuning step, in tenths of a percent of the sample rate
   localparam int RQDS_STEP_PERMILLE = 5;
endpackage : rqds_pkg

/* rtl/rqds_chan_if.sv */
// Interface: per-channel requantizer settings from the bank to each channel slice
`timescale 1ns/100ps
interface rqds_chan_if;
   logic [7:0] ctrl;
   logic [7:0] tune;
   logic modePin;
   logic requantOn;
   logic [2:0] fracCode;
   logic [5:0] tuneWord;
   logic tuneValid;
   modport bank (output ctrl, output tune, output modePin, input requantOn, input fracCode,
      input tuneWord, input tuneValid);
   modport slice (input ctrl, input tune, input modePin, output requantOn, output fracCode,
      output tuneWord, output tuneValid);
endinterface : rqds_chan_if

/* rtl/rqds_chan_decode.sv */
// Module: decodes one channel's requantizer control and tuning settings
`timescale 1ns/100ps
module rqds_chan_decode
   import rqds_pkg::*;
(
   // Channel settings
   rqds_chan_if.slice ch
);
   wire pinDisabled;
   wire [6:0] tuneLimit;
   // Pin governs unless software took control
   assign pinDisabled = ch.ctrl[RQDS_CTRL_PINDIS];
   assign ch.requantOn = pinDisabled ? ch.ctrl[RQDS_CTRL_EN] : ch.modePin;
   assign ch.fracCode = ch.ctrl[RQDS_CTRL_FRAC_LO +: 3];
   assign ch.tuneWord = ch.tune[5:0];
   // Limit of usable tuning words per bandwidth mode
   assign tuneLimit = (ch.fracCode == RQDS_FRAC33) ? RQDS_TUNES_33 :
                      (ch.fracCode == RQDS_FRAC36) ? RQDS_TUNES_36 : RQDS_TUNES_22;
   assign ch.tuneValid = ({1'b0, ch.tuneWord} < tuneLimit);
endmodule : rqds_chan_decode

/* rtl/rqds_regs.sv */
// Module: requantizer and clock-divider sync register bank
// Functional notes
// - No sync function acts unless master sync enable is set.
// - Sync pulse reaches the divider only with divider enable and master enable.
// - Mode bit low: every sync rising edge resets the divider.
// - Mode bit high: only the first next rising edge resets the divider.
// - Bandwidth field 000/001/010 selects 22, 33 or 36 percent.
// - Pin-disable bit chooses register or external mode pin control.
// - Enable bit drives the requantizer only while pin-disable is set.
// - Channel-local writes affect only channels chosen by the channel select mask.
// - Six-bit tuning field positions the enhanced band edges.
// - Valid tuning word counts: 57, 34 and 28 per mode.
// - Each tuning step shifts the band by half a percent.
`timescale 1ns/100ps
module rqds_regs
   import rqds_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   input wire logic clkEn,
   // Register access from the serial port
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic [RQDS_CHANNELS-1:0] chanSelect,
   input wire logic [1:0] readChan,
   output logic [7:0] regRdata,
   output logic regHit,
   // Sync and mode pins
   input wire logic syncIn,
   input wire logic [RQDS_CHANNELS-1:0] modePin,
   // Controls to the datapath
   output logic dividerReset,
   output logic syncPowered,
   output logic [RQDS_CHANNELS-1:0] requantOn,
   output logic [RQDS_CHANNELS*3-1:0] fracCode,
   output logic [RQDS_CHANNELS*6-1:0] tuneWord,
   output logic [RQDS_CHANNELS-1:0] tuneValid
);
   logic [7:0] syncCfg;
   logic [7:0] ctrl [RQDS_CHANNELS];
   logic [7:0] tune [RQDS_CHANNELS];
   logic syncPrev;
   logic oneShotDone;
   wire hitSync;
   wire hitCtrl;
   wire hitTune;
   wire syncRise;
   wire syncGate;
   wire syncFire;
   wire [7:0] readCtrl;
   wire [7:0] readTune;

   // Address decode
   assign hitSync = (regAddr == RQDS_ADDR_SYNC);
   assign hitCtrl = (regAddr == RQDS_ADDR_CTRL);
   assign hitTune = (regAddr == RQDS_ADDR_TUNE);
   assign regHit = hitSync | hitCtrl | hitTune;

   // Global sync register; reserved bits never stored
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         syncCfg <= RQDS_RST_SYNC;
      else if (clkEn && regWrite && hitSync)
         syncCfg <= regWdata & RQDS_MASK_SYNC;
   end

   // Per-channel registers, one generate slice each
   genvar gi;
   generate
      for (gi = 0; gi < RQDS_CHANNELS; gi++)
      begin : gChan
         rqds_chan_if chIf ();
         always_ff @(posedge clk or posedge reset)
         begin
            if (reset)
            begin
               ctrl[gi] <= RQDS_RST_CTRL;
               tune[gi] <= RQDS_RST_TUNE;
            end
            else if (clkEn && regWrite && chanSelect[gi])
            begin
               if (hitCtrl)
                  ctrl[gi] <= regWdata & RQDS_MASK_CTRL;
               if (hitTune)
                  tune[gi] <= regWdata & RQDS_MASK_TUNE;
            end
         end
         assign chIf.ctrl = ctrl[gi];
         assign chIf.tune = tune[gi];
         assign chIf.modePin = modePin[gi];
         rqds_chan_decode uDec (.ch(chIf.slice));
         assign requantOn[gi] = chIf.requantOn;
         assign fracCode[gi*3 +: 3] = chIf.fracCode;
         assign tuneWord[gi*6 +: 6] = chIf.tuneWord;
         assign tuneValid[gi] = chIf.tuneValid;
      end
   endgenerate

   // Readback mux; unmapped offsets read zero
   assign readCtrl = ctrl[readChan];
   assign readTune = tune[readChan];
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         regRdata <= 8'h00;
      else if (clkEn && regRead)
         regRdata <= hitSync ? syncCfg : hitCtrl ? readCtrl : hitTune ? readTune : 8'h00;
   end

   // Sync gating: master and divider enable both required
   assign syncPowered = syncCfg[RQDS_SYNC_MASTER];
   assign syncGate = syncCfg[RQDS_SYNC_MASTER] & syncCfg[RQDS_SYNC_DIVEN];
   assign syncRise = syncIn & ~syncPrev;
   // One-shot mode fires once then ignores later edges until rearmed
   assign syncFire = syncGate & syncRise &
                     (~syncCfg[RQDS_SYNC_MODE] | ~oneShotDone);

   // Edge history and one-shot tracking; rearm by leaving one-shot mode or gating
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         syncPrev <= 1'b0;
         oneShotDone <= 1'b0;
         dividerReset <= 1'b0;
      end
      else if (clkEn)
      begin
         syncPrev <= syncIn;
         dividerReset <= syncFire;
         if (!syncGate || !syncCfg[RQDS_SYNC_MODE])
            oneShotDone <= 1'b0;
         else if (syncFire)
            oneShotDone <= 1'b1;
      end
   end

   // Checks
   // Sequences keep the one-shot steps apart: armed edge, fired, then spent
   // A sync edge seen while both enables are set
   sequence syncEdgeSeq;
      clkEn && syncGate && syncRise;
   endsequence
   // The first edge after arming in one-shot mode
   sequence oneShotArmSeq;
      clkEn && syncGate && syncRise && syncCfg[RQDS_SYNC_MODE] && !oneShotDone;
   endsequence
   // Any later cycle of one-shot mode once the divider was reset
   sequence oneShotSpentSeq;
      clkEn && syncGate && syncCfg[RQDS_SYNC_MODE] && oneShotDone;
   endsequence
   property resetFollowsEdge;
      @(posedge clk) disable iff (reset)
         syncEdgeSeq and (!syncCfg[RQDS_SYNC_MODE]) |=> dividerReset;
   endproperty
   property oneShotFires;
      @(posedge clk) disable iff (reset)
         oneShotArmSeq |=> dividerReset;
   endproperty
   property oneShotHolds;
      @(posedge clk) disable iff (reset)
         oneShotSpentSeq |=> !dividerReset;
   endproperty

   // Sync gating and divider reset pulses
   master_gate_a: assert property (@(posedge clk) disable iff (reset)
      clkEn && !syncCfg[RQDS_SYNC_MASTER] |=> !dividerReset)
      else $error("divider reset without master sync enable");
   divider_gate_a: assert property (@(posedge clk) disable iff (reset)
      clkEn && syncRise && !syncGate |=> !dividerReset)
      else $error("divider reset while divider sync disabled");
   cont_sync_a: assert property (resetFollowsEdge)
      else $error("continuous mode missed a sync edge");
   one_shot_a: assert property (oneShotHolds)
      else $error("one-shot mode reset divider twice");
   first_shot_a: assert property (oneShotFires)
      else $error("one-shot mode missed its first sync edge");

   // Requantizer control decode; channel 0 stands for all slices
   pin_ctrl_a: assert property (@(posedge clk) disable iff (reset)
      !ctrl[0][RQDS_CTRL_PINDIS] |-> requantOn[0] == modePin[0])
      else $error("requantizer enable ignored mode pin");
   pin_dis_a: assert property (@(posedge clk) disable iff (reset)
      ctrl[0][RQDS_CTRL_PINDIS] |-> requantOn[0] == ctrl[0][RQDS_CTRL_EN])
      else $error("requantizer enable ignored register bit");
   frac_field_a: assert property (@(posedge clk) disable iff (reset)
      fracCode[2:0] == ctrl[0][3:1])
      else $error("bandwidth code mismatch");
   tune_map_a: assert property (@(posedge clk) disable iff (reset)
      tuneWord[5:0] == tune[0][5:0])
      else $error("tuning word does not follow its register");
   tune_count_a: assert property (@(posedge clk) disable iff (reset)
      fracCode[2:0] == RQDS_FRAC36 && tuneWord[5:0] == 6'h1C |-> !tuneValid[0])
      else $error("tuning word beyond 36 percent range reported valid");
   tune_last_a: assert property (@(posedge clk) disable iff (reset)
      fracCode[2:0] == RQDS_FRAC22 && tuneWord[5:0] == 6'h38 |-> tuneValid[0])
      else $error("last 22 percent tuning word reported invalid");

   // Register access, masking and clock-enable freeze
   chan_write_a: assert property (@(posedge clk) disable iff (reset)
      clkEn && regWrite && hitTune && !chanSelect[1] |=> $stable(tune[1]))
      else $error("unselected channel written");
   sync_write_a: assert property (@(posedge clk) disable iff (reset)
      clkEn && regWrite && hitSync |=> syncCfg == ($past(regWdata) & RQDS_MASK_SYNC))
      else $error("sync register write did not land masked");
   unmapped_read_a: assert property (@(posedge clk) disable iff (reset)
      clkEn && regRead && !regHit |=> regRdata == 8'h00)
      else $error("unmapped offset read nonzero");
   freeze_a: assert property (@(posedge clk) disable iff (reset)
      !clkEn |=> $stable(syncCfg) && $stable(dividerReset) && $stable(tune[0]))
      else $error("state moved while clock enable low");
   reserved_a: assert property (@(posedge clk) disable iff (reset)
      syncCfg[7:3] == 5'h00 && tune[0][7:6] == 2'h0 && ctrl[0][7:5] == 3'h0)
      else $error("reserved bit stored");
endmodule : rqds_regs

/* test/rqds_host.sv */
// Host controller model: serial-port register accesses to the bank
`timescale 1ns/100ps
module rqds_host
   import rqds_pkg::*;
(
   // Clock
   input wire logic clk,
   // Register access
   output logic regWrite,
   output logic regRead,
   output logic [7:0] regAddr,
   output logic [7:0] regWdata,
   output logic [RQDS_CHANNELS-1:0] chanSelect,
   output logic [1:0] readChan
);
   // Port idle unless a test asks
   initial {regWrite, regRead, regAddr, regWdata, chanSelect, readChan} = '0;
   // One access held over one edge, then one idle edge so strobes never retoggle at once
   // Master stays off until sync is tested
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
      input logic [3:0] m, input logic [1:0] c);
      regWrite = w;
      regRead = !w;
      regAddr = a;
      regWdata = d;
      chanSelect = m;
      readChan = c;
      @(posedge clk);
      #1;
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = ~a; // Released address shows no stale value
      @(posedge clk);
      #1;
   endtask : acc
endmodule : rqds_host

/* test/requantizer_and_divider_sync_regs_tb.sv */
// Testbench: requantizer and sync register bank driven by the host model
`timescale 1ns/100ps
module requantizer_and_divider_sync_regs_tb
   import rqds_pkg::*;
;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic syncIn = 1'b0;
   logic [3:0] modePin = 4'h0;
   logic regWrite, regRead, regHit, dividerReset, syncPowered;
   logic [7:0] regAddr, regWdata, regRdata, rv;
   logic clkEn = 1'b1;
   logic [3:0] chanSelect, requantOn, tuneValid;
   logic [1:0] readChan;
   logic [11:0] fracCode;
   logic [23:0] tuneWord;
   logic [7:0] sCfg[4] = '{8'h02, 8'h01, 8'h03, 8'h07};
   int sExp[4] = '{0, 0, 3, 1};
   int bad_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   int pulses = 0;
   always #4 clk = ~clk;
   rqds_host host (.clk(clk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
      .regWdata(regWdata), .chanSelect(chanSelect), .readChan(readChan));
   rqds_regs dut (.clk(clk), .reset(reset), .clkEn(clkEn), .regWrite(regWrite),
      .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .chanSelect(chanSelect),
      .readChan(readChan), .regRdata(regRdata), .regHit(regHit), .syncIn(syncIn),
      .modePin(modePin), .dividerReset(dividerReset), .syncPowered(syncPowered),
      .requantOn(requantOn), .fracCode(fracCode), .tuneWord(tuneWord),
      .tuneValid(tuneValid));
   // Count divider resets; hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (dividerReset === 1'b1)
         pulses++;
      if (cycles == 5000)
      begin
         bad_count++;
         final_report();
      end
   end
   function automatic logic [6:0] tune_count(input int b);
      return (b == 0) ? 7'd57 : (b == 1) ? 7'd34 : 7'd28;
   endfunction : tune_count
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic rd(input logic [7:0] a, input logic [1:0] c, input logic [7:0] exp);
      // Address decode looked at while the request stands
      fork
         host.acc(1'b0, a, 8'h00, 4'h0, c);
         begin
            #2;
            chk(regHit, (a == 8'h3A) || (a == 8'h3C) || (a == 8'h3E));
         end
      join
      chk(regRdata, exp);
   endtask : rd
   // Rising sync edge, then low again
   task automatic fire();
      syncIn = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      syncIn = 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask : fire
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : final_report
   initial
   begin
      rv = 8'($urandom(32'hFED2D7C1));
      repeat (8) @(posedge clk);
      #1;
      reset = 1'b0;
      rd(8'h3A, 2'd0, 8'h00);
      for (int c = 0; c < 4; c++)
      begin
         rd(8'h3C, c[1:0], 8'h00);
         rd(8'h3E, c[1:0], 8'h1C);
      end
      rd(8'h40, 2'd0, 8'h00);
      $display("Reset values test done");
      // Masked write with reserved bits set; unselected channel keeps its value
      rv = 8'($urandom);
      host.acc(1'b1, 8'h3E, rv | 8'hC0, 4'h5, 2'd0);
      rd(8'h3E, 2'd0, rv & 8'h3F);
      rd(8'h3E, 2'd1, 8'h1C);
      chk(tuneWord[11:6], 6'h1C);
      host.acc(1'b1, 8'h3A, 8'hF8, 4'h0, 2'd0);
      rd(8'h3A, 2'd0, 8'h00);
      $display("Channel mask test done");
      // Each bandwidth code at the last valid tuning word and one past it
      for (int b = 0; b < 3; b++)
         for (int k = 0; k < 2; k++)
         begin
            host.acc(1'b1, 8'h3C, 8'(b * 2), 4'hF, 2'd0);
            host.acc(1'b1, 8'h3E, 8'(tune_count(b) - 7'd1 + 7'(k)), 4'hF, 2'd0);
            chk(fracCode, {4{3'(b)}});
            chk(tuneWord, {4{6'(tune_count(b) - 7'd1 + 7'(k))}});
            chk(tuneValid, {4{k == 0}});
         end
      $display("Bandwidth test done");
      // Clock enable low freezes the bank: this write must not land
      clkEn = 1'b0;
      host.acc(1'b1, 8'h3E, 8'h05, 4'hF, 2'd0);
      clkEn = 1'b1;
      rd(8'h3E, 2'd0, 8'(tune_count(2)));
      $display("Clock enable test done");
      // Pin versus register control of the requantizer
      for (int i = 0; i < 4; i++)
      begin
         modePin = 4'($urandom);
         host.acc(1'b1, 8'h3C, {3'h0, i[1], 3'h0, i[0]}, 4'hF, 2'd0);
         chk(requantOn, i[1] ? {4{i[0]}} : modePin);
      end
      $display("Mode control test done");
      // Master off, divider off, continuous, then one-shot
      for (int m = 0; m < 4; m++)
      begin
         host.acc(1'b1, 8'h3A, sCfg[m], 4'h0, 2'd0);
         chk(syncPowered, sCfg[m][0]);
         pulses = 0;
         repeat (3) fire();
         chk(24'(pulses), 24'(sExp[m]));
      end
      $display("Sync test done");
      final_report();
   end
endmodule : requantizer_and_divider_sync_regs_tb
